/* File: lsrt_defines.vh */
// register offsets, field layouts, reset values and limits of the line
// scan readout and trigger block; included by lsrt_top.v and lsrt_line_mem.v.
`ifndef LSRT_DEFINES_VH
`define LSRT_DEFINES_VH
`define LSRT_A_CTRL 12'h000
`define LSRT_A_WIDTH 12'h004
`define LSRT_A_OFFSET 12'h008
`define LSRT_A_PERIOD 12'h00c
`define LSRT_A_HOLDOFF 12'h010
`define LSRT_A_CMD 12'h014
`define LSRT_A_STATUS 12'h018
`define LSRT_A_LINES 12'h01c
`define LSRT_A_HEIGHT 12'h020
// ctrl fields
`define LSRT_C_COMB 0
`define LSRT_C_AVG 1
`define LSRT_C_MIRR 2
`define LSRT_C_EXT 3
`define LSRT_C_FN_LO 4
`define LSRT_C_FN_HI 5
`define LSRT_C_ENC_LO 6
`define LSRT_C_ENC_HI 7
`define LSRT_C_COLOR 8
`define LSRT_FN_BEGIN 2'h0
`define LSRT_FN_FINISH 2'h1
`define LSRT_FN_SINGLE 2'h2
`define LSRT_ENC_8 2'h0
`define LSRT_ENC_10 2'h1
`define LSRT_ENC_12 2'h2
`define LSRT_CTRL_RST 9'h000
`define LSRT_LINE_PIX 2048
`define LSRT_BIN_PIX 1024
`define LSRT_WMIN 12'd128
`define LSRT_WMIN_BIN 12'd64
`define LSRT_WIDTH_RST 12'd2048
`define LSRT_OFFSET_RST 12'd0
`define LSRT_HEIGHT 32'h0000_0001
`define LSRT_CLK_HZ 100000000
`define LSRT_MIN_HZ 66
`define LSRT_MONO_MAX_HZ 172000
`define LSRT_TRI_MAX_HZ 44000
// period limits in clock cycles: longest rounds down, shortest rounds up
`define LSRT_PER_MAX 32'd1515151
`define LSRT_PER_MIN_MONO 32'd582
`define LSRT_PER_MIN_TRI 32'd2273
`define LSRT_PERIOD_RST 32'd100000
`define LSRT_HOLD_RST 16'h0000
`endif

/* File: lsrt_line_mem.v */
// one sensor line store, 2048 words of 12 bits, registered read.
// assumes one write port from the sensor side and one read address.
`timescale 1ns/10ps
`include "lsrt_defines.vh"
module lsrt_line_mem (
  input wire clock,
  input wire we,
  input wire [10:0] waddr,
  input wire [11:0] wdata,
  input wire [10:0] raddr,
  output reg [11:0] rdata
);
  reg [11:0] mem [0:`LSRT_LINE_PIX-1];
  always @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* File: lsrt_top.v */
// line scan readout: region select, pair combine, mirror, encoding and
// line pacing by free-run generator, with holdoff except under the external finish function, or by external pulse without holdoff.
// assumes apb master on clock, sensor pixels in order after sensor_line_start,
// and an asynchronous external pulse pin.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "lsrt_defines.vh"
module lsrt_top (
  input wire clock,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire ext_pulse,
  output reg sensor_line_start,
  input wire sensor_pix_valid,
  input wire [11:0] sensor_pix,
  output reg pix_valid,
  output reg [11:0] pix_data,
  output reg pix_first,
  output reg pix_last,
  output wire capture_active
);
  localparam S_IDLE = 3'b001;
  localparam S_FILL = 3'b010;
  localparam S_OUT = 3'b100;

  reg [8:0] ctrl_r;
  reg [11:0] width_r;
  reg [11:0] offset_r;
  reg [31:0] period_r;
  reg [15:0] holdoff_r;
  reg running_r;
  reg armed_r;
  reg [15:0] hold_cnt_r;
  reg [31:0] rate_cnt_r;
  reg [31:0] lines_r;
  reg ext_s1_r, ext_s2_r, ext_s3_r;
  reg [2:0] st_r;
  reg [10:0] wr_idx_r;
  reg [11:0] rd_idx_r;
  reg half_r;
  reg [12:0] acc_r;
  reg out_en_r;
  reg rd_v_r;
  reg rd_first_r;
  reg rd_last_r;
  reg last_drop_r;

  wire comb = ctrl_r[`LSRT_C_COMB];
  wire [1:0] fn = ctrl_r[`LSRT_C_FN_HI:`LSRT_C_FN_LO];
  wire [1:0] enc = ctrl_r[`LSRT_C_ENC_HI:`LSRT_C_ENC_LO];
  wire ext_mode = ctrl_r[`LSRT_C_EXT];
  wire wr = psel && penable && pwrite;
  wire [11:0] rd_data;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign capture_active = running_r;

  // pin input passes two flops; third flop only for edge detection
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_pulse;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end
  wire ext_edge = ext_s2_r && !ext_s3_r;

  // range checks against the combining and color settings in force after the write
  wire [1:0] fn_new = pwdata[`LSRT_C_FN_HI:`LSRT_C_FN_LO];
  wire [1:0] enc_new = pwdata[`LSRT_C_ENC_HI:`LSRT_C_ENC_LO];
  wire [12:0] lim = comb ? 13'd1024 : 13'd2048;
  wire [11:0] wmin = comb ? `LSRT_WMIN_BIN : `LSRT_WMIN;
  wire [12:0] w_new = {1'b0, pwdata[11:0]};
  wire [12:0] o_new = {1'b0, pwdata[11:0]};
  wire w_ok = (pwdata[31:12] == 20'h0) && (pwdata[2:0] == 3'h0) &&
    (pwdata[11:0] >= wmin) && (w_new + {1'b0, offset_r} <= lim);
  wire o_ok = (pwdata[31:12] == 20'h0) && (pwdata[2:0] == 3'h0) &&
    (o_new + {1'b0, width_r} <= lim);
  wire [31:0] per_min = ctrl_r[`LSRT_C_COLOR] ? `LSRT_PER_MIN_TRI :
    `LSRT_PER_MIN_MONO;
  // combining can be enabled only when the present region fits binned line
  wire c_ok = !pwdata[`LSRT_C_COMB] || comb ||
    ({1'b0, width_r} + {1'b0, offset_r} <= 13'd1024 &&
     width_r >= `LSRT_WMIN_BIN);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `LSRT_CTRL_RST;
      width_r <= `LSRT_WIDTH_RST;
      offset_r <= `LSRT_OFFSET_RST;
      period_r <= `LSRT_PERIOD_RST;
      holdoff_r <= `LSRT_HOLD_RST;
    end else if (wr) begin
      if (paddr == `LSRT_A_CTRL) begin
        if (c_ok && fn_new != 2'h3 && enc_new != 2'h3) begin
          ctrl_r <= pwdata[8:0];
        end
      end else if (paddr == `LSRT_A_WIDTH) begin
        if (w_ok) begin
          width_r <= pwdata[11:0];
        end
      end else if (paddr == `LSRT_A_OFFSET) begin
        if (o_ok) begin
          offset_r <= pwdata[11:0];
        end
      end else if (paddr == `LSRT_A_PERIOD) begin
        if (pwdata <= `LSRT_PER_MAX && pwdata >= per_min) begin
          period_r <= pwdata;
        end
      end else if (paddr == `LSRT_A_HOLDOFF) begin
        holdoff_r <= pwdata[15:0];
      end
    end
  end

  always @* begin
    prdata = 32'h0000_0000;
    if (paddr == `LSRT_A_CTRL) begin
      prdata = {23'h0, ctrl_r};
    end else if (paddr == `LSRT_A_WIDTH) begin
      prdata = {20'h0, width_r};
    end else if (paddr == `LSRT_A_OFFSET) begin
      prdata = {20'h0, offset_r};
    end else if (paddr == `LSRT_A_PERIOD) begin
      prdata = period_r;
    end else if (paddr == `LSRT_A_HOLDOFF) begin
      prdata = {16'h0, holdoff_r};
    end else if (paddr == `LSRT_A_STATUS) begin
      prdata = {29'h0, st_r != S_IDLE, out_en_r, running_r};
    end else if (paddr == `LSRT_A_LINES) begin
      prdata = lines_r;
    end else if (paddr == `LSRT_A_HEIGHT) begin
      prdata = `LSRT_HEIGHT;
    end
  end

  // command register: bit0 begin, bit1 finish
  wire cmd_wr = wr && (paddr == `LSRT_A_CMD);
  wire sw_begin = cmd_wr && pwdata[0];
  wire sw_finish = cmd_wr && pwdata[1];
  wire hw_begin = ext_mode && fn == `LSRT_FN_BEGIN && ext_edge &&
    armed_r;
  wire hw_finish = ext_mode && fn == `LSRT_FN_FINISH && ext_edge;

  // free-run generator counts period_r clocks per line
  wire tick = (rate_cnt_r >= period_r - 32'd1);
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate_cnt_r <= 32'd0;
    end else if (tick || !running_r) begin
      rate_cnt_r <= 32'd0;
    end else begin
      rate_cnt_r <= rate_cnt_r + 32'd1;
    end
  end

  // line request: single-row pulses, otherwise the internal generator
  wire line_req = running_r && (ext_mode ?
    (fn == `LSRT_FN_SINGLE && ext_edge) : tick);
  // begin/finish functions still pace lines from the generator once running
  wire line_go = line_req || (running_r && ext_mode &&
    fn != `LSRT_FN_SINGLE && tick);
  // a request while the previous line is still busy is dropped
  wire line_take = line_go && st_r == S_IDLE;

  wire hold_zero = ext_mode && fn != `LSRT_FN_BEGIN;
  wire [15:0] hold_eff = hold_zero ? 16'h0000 : holdoff_r;

  // a begin pulse counts only after the host has armed capture
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (sw_finish) begin
      armed_r <= 1'b0;
    end else if (sw_begin) begin
      armed_r <= 1'b1;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      running_r <= 1'b0;
      hold_cnt_r <= 16'h0000;
      out_en_r <= 1'b0;
    end else begin
      if (sw_finish || hw_finish) begin
        running_r <= 1'b0;
        out_en_r <= 1'b0;
      end else if ((sw_begin && !(ext_mode && fn == `LSRT_FN_BEGIN)) ||
                   hw_begin) begin
        running_r <= 1'b1;
        hold_cnt_r <= 16'h0000;
        out_en_r <= (hold_eff == 16'h0000);
      end else if (line_take && !out_en_r) begin
        // one unit per line taken, whatever paces it; requests dropped while busy do not count
        if (hold_cnt_r + 16'h0001 >= hold_eff) begin
          out_en_r <= 1'b1;
        end
        hold_cnt_r <= hold_cnt_r + 16'h0001;
      end
    end
  end

  // readout: capture full sensor line, then stream the region from memory unless the line falls in the holdoff
  wire [12:0] rd_last_idx = {1'b0, width_r} - 13'd1;
  wire [11:0] rel = ctrl_r[`LSRT_C_MIRR] ?
    (rd_last_idx[11:0] - rd_idx_r) : rd_idx_r;
  // binned region refers to combined pixels, so sensor index doubles
  wire [12:0] base = comb ? {offset_r, 1'b0} + {rel, 1'b0} + {12'h0, half_r}
    : {1'b0, offset_r} + {1'b0, rel};
  wire [10:0] raddr = base[10:0];

  lsrt_line_mem u_mem (
    .clock(clock),
    .we(st_r == S_FILL && sensor_pix_valid),
    .waddr(wr_idx_r),
    .wdata(sensor_pix),
    .raddr(raddr),
    .rdata(rd_data)
  );

  wire pix_done = !comb || half_r;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      wr_idx_r <= 11'h000;
      rd_idx_r <= 12'h000;
      half_r <= 1'b0;
      sensor_line_start <= 1'b0;
      rd_v_r <= 1'b0;
      rd_first_r <= 1'b0;
      rd_last_r <= 1'b0;
      last_drop_r <= 1'b0;
      lines_r <= 32'd0;
    end else begin
      sensor_line_start <= 1'b0;
      rd_v_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (line_take) begin
            sensor_line_start <= 1'b1;
            wr_idx_r <= 11'h000;
            last_drop_r <= !out_en_r;
            st_r <= S_FILL;
          end
        end
        S_FILL: begin
          if (sensor_pix_valid) begin
            wr_idx_r <= wr_idx_r + 11'h001;
            if (wr_idx_r == 11'h7ff) begin
              rd_idx_r <= 12'h000;
              half_r <= 1'b0;
              st_r <= last_drop_r ? S_IDLE : S_OUT;
            end
          end
        end
        S_OUT: begin
          rd_v_r <= pix_done;
          rd_first_r <= rd_idx_r == 12'h000;
          rd_last_r <= {1'b0, rd_idx_r} == rd_last_idx;
          half_r <= comb ? !half_r : 1'b0;
          if (pix_done) begin
            rd_idx_r <= rd_idx_r + 12'h001;
            if ({1'b0, rd_idx_r} == rd_last_idx) begin
              st_r <= S_IDLE;
              lines_r <= lines_r + 32'd1;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // pair combine and encoding on registered memory data
  reg [12:0] pair;
  reg [11:0] enc_pix;
  always @* begin
    pair = ctrl_r[`LSRT_C_AVG] ? {1'b0, acc_r[12:1]} : acc_r;
    if (!comb) begin
      pair = {1'b0, rd_data};
    end else if (!ctrl_r[`LSRT_C_AVG] && acc_r[12]) begin
      pair = 13'h0fff; // sum saturates rather than wraps
    end
    enc_pix = pair[11:0];
    if (enc == `LSRT_ENC_8) begin
      enc_pix = {4'h0, pair[11:4]};
    end else if (enc == `LSRT_ENC_10) begin
      enc_pix = {2'h0, pair[11:2]};
    end
  end

  reg [11:0] first_half_r;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      first_half_r <= 12'h000;
    end else if (rd_v_r == 1'b0) begin
      first_half_r <= rd_data;
    end
  end
  always @* begin
    acc_r = {1'b0, first_half_r} + {1'b0, rd_data};
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pix_valid <= 1'b0;
      pix_data <= 12'h000;
      pix_first <= 1'b0;
      pix_last <= 1'b0;
    end else begin
      pix_valid <= rd_v_r;
      pix_data <= enc_pix;
      pix_first <= rd_v_r && rd_first_r;
      pix_last <= rd_v_r && rd_last_r;
    end
  end
endmodule

/* File: lsrt_properties.sv */
// port checker for lsrt_top: apb answers, line requests, pixel framing
// assumes lsrt_defines.vh and binding onto lsrt_top
`timescale 1ns/10ps
`include "lsrt_defines.vh"
module lsrt_properties (
  input wire clock,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire sensor_line_start,
  input wire pix_valid,
  input wire pix_first,
  input wire pix_last,
  input wire capture_active
);
  logic in_line_r;
  logic [11:0] cnt_r;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_line_r <= 1'b0;
      cnt_r <= 12'h000;
    end else if (pix_valid) begin
      in_line_r <= !pix_last;
      cnt_r <= pix_last ? 12'h000 : cnt_r + 12'h001;
    end
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    sensor_line_start;
  endsequence
  sequence s_quiet;
    !sensor_line_start [*8];
  endsequence
  sequence s_height_rd;
    psel && penable && !pwrite && paddr == `LSRT_A_HEIGHT;
  endsequence
  AST_APB_OKAY: assert property (psel |-> pready && !pslverr)
    else $error("apb answer not ready or in error");
  AST_HEIGHT_ONE: assert property (s_height_rd |-> prdata == 32'h1)
    else $error("height reads other than one");
  AST_REQ_SPACED: assert property (s_req |=> s_quiet)
    else $error("second line request while busy");
  AST_REQ_RUNNING: assert property (s_req |-> $past(capture_active))
    else $error("line request while capture idle");
  AST_MARK_VALID: assert property ((pix_first || pix_last) |-> pix_valid)
    else $error("line marker without pixel");
  AST_ONE_LINE: assert property (pix_valid && !pix_first |-> in_line_r)
    else $error("pixel outside a line");
  AST_FIRST_NEW: assert property (pix_first |-> !in_line_r)
    else $error("line start inside a line");
  AST_WIDTH_CAP: assert property (pix_valid |-> cnt_r < 12'd2048)
    else $error("line longer than sensor");
  AST_WIDTH_MIN: assert property (pix_last |-> cnt_r >= 12'd63)
    else $error("line shorter than smallest width");
  AST_RESET_IDLE: assert property ($rose(rst_n) |-> !capture_active)
    else $error("capture running after reset");
endmodule
bind lsrt_top lsrt_properties u_props (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sensor_line_start(sensor_line_start),
  .pix_valid(pix_valid), .pix_first(pix_first), .pix_last(pix_last),
  .capture_active(capture_active)
);

/* File: lsrt_sensor_model.sv */
// sensor line model: 2048 pixels after each line request
// assumes one request at a time; pixel value is its index rounded even
`timescale 1ns/10ps
module lsrt_sensor_model #(
  parameter GAP = 2,
  parameter STALL = 0
) (
  input wire clock,
  input wire rst_n,
  input wire line_start,
  output reg pix_valid,
  output reg [11:0] pix
);
  int pos = -1;
  int dly = 0;
  int tick = 0;
  initial pix_valid = 1'b0;
  initial pix = 12'h000;
  always @(posedge clock) begin
    tick <= tick + 1;
    pix_valid <= 1'b0;
    // idle data toggles so a stale pixel never looks good
    pix <= ~pix;
    if (!rst_n)
      pos <= -1;
    else if (line_start) begin
      pos <= 0;
      dly <= GAP;
    end else if (dly > 0)
      dly <= dly - 1;
    else if (pos >= 0 && !(STALL != 0 && tick % 2 == 1)) begin
      pix_valid <= 1'b1;
      pix <= {pos[10:1], 1'b0};
      pos <= (pos == 2047) ? -1 : pos + 1;
    end
  end
endmodule

/* File: tb_top.sv */
// self-checking bench for lsrt_top with the sensor model
// assumes lsrt_defines.vh register map and an apb slave that may stall
`timescale 1ns/10ps
`include "lsrt_defines.vh"
module tb_top;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d, e;} lsrt_row_t;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic ext_pulse = 0;
  logic [11:0] paddr = 12'h000, sensor_pix, pix_data;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, sensor_line_start, sensor_pix_valid;
  logic pix_valid, pix_first, pix_last, capture_active;
  int bad_count = 0, n_compared = 0, n_start = 0, n_lines = 0;
  int l0, s0, f0;
  logic [11:0] q[$];
  logic [8:0] lc[4] = '{9'h0a8, 9'h06c, 9'h029, 9'h0af};
  lsrt_row_t rows[28] = '{
    '{0, `LSRT_A_CTRL, 0, 0}, '{0, `LSRT_A_WIDTH, 0, 2048},
    '{0, `LSRT_A_OFFSET, 0, 0}, '{0, `LSRT_A_PERIOD, 0, 100000},
    '{0, `LSRT_A_HEIGHT, 0, 1}, '{0, 12'h040, 0, 0},
    '{0, `LSRT_A_STATUS, 0, 0}, '{0, `LSRT_A_LINES, 0, 0},
    '{1, `LSRT_A_WIDTH, 100, 2048}, '{1, `LSRT_A_WIDTH, 120, 2048},
    '{1, `LSRT_A_OFFSET, 8, 0}, '{1, `LSRT_A_WIDTH, 136, 136},
    '{1, `LSRT_A_OFFSET, 1912, 1912}, '{1, `LSRT_A_OFFSET, 1920, 1912},
    '{1, `LSRT_A_PERIOD, 581, 100000}, '{1, `LSRT_A_PERIOD, 1515152, 100000},
    '{1, `LSRT_A_OFFSET, 8, 8}, '{1, `LSRT_A_WIDTH, 128, 128},
    '{1, `LSRT_A_CTRL, 1, 1}, '{1, `LSRT_A_WIDTH, 56, 128},
    '{1, `LSRT_A_OFFSET, 904, 8}, '{1, `LSRT_A_CTRL, 0, 0},
    '{1, `LSRT_A_PERIOD, 3000, 3000}, '{1, `LSRT_A_HOLDOFF, 2, 2},
    '{1, `LSRT_A_CTRL, 256, 256}, '{1, `LSRT_A_PERIOD, 2272, 3000},
    '{1, `LSRT_A_CTRL, 192, 256}, '{1, `LSRT_A_CTRL, 0, 0}};
  always #5 clock = ~clock;
  lsrt_top DUT (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_pulse(ext_pulse), .sensor_line_start(sensor_line_start),
    .sensor_pix_valid(sensor_pix_valid), .sensor_pix(sensor_pix),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_first(pix_first),
    .pix_last(pix_last), .capture_active(capture_active));
  lsrt_sensor_model #(.GAP(2), .STALL(0)) u_sensor (.clock(clock),
    .rst_n(rst_n), .line_start(sensor_line_start),
    .pix_valid(sensor_pix_valid), .pix(sensor_pix));
  always @(posedge clock) begin
    if (pix_valid && pix_first)
      f0 = q.size();
    if (pix_valid)
      q.push_back(pix_data);
    if (pix_valid && pix_last)
      n_lines++;
    if (sensor_line_start)
      n_start++;
  end
  task chk(string s, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task pulse;
    ext_pulse <= 1'b1;
    repeat (4) @(posedge clock);
    ext_pulse <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  // expected pixel: sensor value is its even index, binned pairs are equal
  function automatic logic [11:0] pexp(logic [8:0] c, int j);
    int m;
    int v;
    m = 8 + (c[2] ? 127 - j : j);
    v = c[0] ? (c[1] ? 2 * m : 4 * m) : (m / 2) * 2;
    return v >> (4 - 2 * int'(c[7:6]));
  endfunction
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      if (rows[i].w)
        apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("register", rows[i].e, r);
    end
    foreach (lc[i]) begin
      apb(1'b1, `LSRT_A_CMD, 32'h2);
      apb(1'b1, `LSRT_A_CTRL, {23'h0, lc[i]});
      apb(1'b1, `LSRT_A_CMD, 32'h1);
      q.delete();
      f0 = -1;
      l0 = n_lines;
      pulse();
      for (int k = 0; k < 8000 && n_lines == l0; k++) @(posedge clock);
      repeat (4) @(posedge clock);
      chk("line length", 128, q.size());
      chk("first index", 0, f0);
      for (int j = 0; j < 128; j++)
        chk("pixel", pexp(lc[i], j), q[j]);
    end
    apb(1'b1, `LSRT_A_CMD, 32'h2);
    apb(1'b1, `LSRT_A_CTRL, 32'h0);
    repeat (4000) @(posedge clock);
    s0 = n_start;
    l0 = n_lines;
    apb(1'b1, `LSRT_A_CMD, 32'h1);
    repeat (15000) @(posedge clock);
    apb(1'b1, `LSRT_A_CMD, 32'h2);
    repeat (4000) @(posedge clock);
    chk("masked", 2, (n_start - s0) - (n_lines - l0));
    chk("line rate", 1, (n_start - s0) inside {[4:6]});
    apb(1'b1, `LSRT_A_CTRL, 32'h18);
    apb(1'b1, `LSRT_A_CMD, 32'h1);
    chk("running", 1, capture_active);
    pulse();
    chk("halted", 0, capture_active);
    apb(1'b1, `LSRT_A_CTRL, 32'h08);
    pulse();
    chk("started", 1, capture_active);
    apb(1'b1, `LSRT_A_CMD, 32'h2);
    pulse();
    chk("no restart", 0, capture_active);
    repeat (4000) @(posedge clock);
    l0 = n_lines;
    apb(1'b1, `LSRT_A_CTRL, 32'h28);
    pulse();
    repeat (4000) @(posedge clock);
    chk("after finish", l0, n_lines);
    apb(1'b1, `LSRT_A_CMD, 32'h1);
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("reset idle", 0, capture_active);
    apb(1'b0, `LSRT_A_WIDTH, 32'h0);
    chk("reset width", 2048, r);
    test_done();
  end
  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    test_done();
  end
endmodule
